// file: design/eep_pkg.sv
/*
  Package for the serial EEPROM slave: address codes, array size,
  page size and write cycle timing.
  Assumes a 50 MHz system clock.
*/
package eep_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WR_TIME_US = 5000;
  localparam int unsigned WR_CYCLES = (WR_TIME_US * (CLK_HZ / 1_000_000)) - 1;
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam int unsigned DEPTH = 256;
  localparam int unsigned PAGE_BYTES = 8;
  localparam int unsigned PAGE_AW = 3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] ARR_RST = 8'hFF;
  typedef enum logic [2:0] {
    EEP_IDLE, EEP_DEVADDR, EEP_ACK, EEP_WADDR, EEP_WDATA, EEP_RDATA, EEP_RACK, EEP_SKIP
  } eep_state_t;
  typedef enum logic [1:0] {
    EEP_WR_IDLE, EEP_WR_PROG, EEP_WR_WAIT
  } eep_wstate_t;
endpackage

// file: design/eep_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/100ps
module eep_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wp_q;
  logic [PW:0] rp_q;
  logic push;
  logic pop;

  assign in_ready_o = (wp_q - rp_q) != (PW+1)'(DEPTH);
  assign out_valid_o = wp_q != rp_q;
  assign out_data_o = mem_q[rp_q[PW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (ce_i && push) begin
      mem_q[wp_q[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        wp_q <= '0;
        rp_q <= '0;
      end else begin
        if (push) begin
          wp_q <= wp_q + 1'b1;
        end
        if (pop) begin
          rp_q <= rp_q + 1'b1;
        end
      end
    end
  end
endmodule

// file: design/eep_slave.sv
/*
  Two-wire serial EEPROM slave, 256 x 8, with page write buffer,
  write guard and self-timed programming.
  Assumes SCL and SDA arrive asynchronously and are sampled at 50 MHz;
  the far side supplies the pull-up on SDA.
*/
`timescale 1ns/100ps
// How it works
// [RULE_01] The three strap inputs form the low part of the bus address, allowing eight devices.
// [RULE_02] The device answers only when the code and strap bits both match the address byte.
// [RULE_03] Command and write bits are taken at the rising edge of SCL.
// [RULE_04] Read bits change only after a falling SCL edge and hold through the high phase.
// [RULE_05] With the guard high, writes to addresses 128 to 255 are dropped.
// [RULE_06] With the guard low, every address is writable.
// [RULE_07] The array is 256 words of 8 bits, chosen by an 8-bit address.
// [RULE_08] Up to 16 bytes per page write are buffered, the address wrapping within the 8-byte page; shorter pages are also accepted.
// [RULE_09] After the stop, the array is programmed in a cycle of at most 5 ms.
// [RULE_10] Undriven strap and guard inputs are taken as low.
// [RULE_11] SDA is only pulled low or released.
// [RULE_12] The master keeps SCL high while the bus is idle.
// [RULE_13] Random reads and sequential reads through consecutive addresses are supported.
// [RULE_14] SCL rates up to 1 MHz are handled by oversampling at 50 MHz.
// [RULE_15] The master starts every transfer; the device is only a slave.
// [RULE_16] During programming the device does not acknowledge and ignores commands.
module eep_slave #(
  parameter int unsigned WR_CYCLES = eep_pkg::WR_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_strap_bit0_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  input wire logic write_guard_i,
  output logic busy_o
);
  localparam int unsigned FW = eep_pkg::AW + eep_pkg::DW;

  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic [1:0] a0_s_q;
  logic [1:0] a1_s_q;
  logic [1:0] a2_s_q;
  logic [1:0] wg_s_q;
  logic scl_d1_q;
  logic sda_d1_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  eep_pkg::eep_state_t st_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic rd_mode_q;
  logic ack_to_addr_q;
  logic [7:0] ptr_q;
  logic [3:0] pg_cnt_q;
  logic sda_oe_q;
  logic ack_data_q;
  logic rd_first_q;
  logic sda_lo_q;
  logic [7:0] mem_q [eep_pkg::DEPTH];

  eep_pkg::eep_wstate_t wst_q;
  logic [31:0] wcnt_q;
  logic busy_q;
  logic f_in_valid;
  logic f_in_ready;
  logic [FW-1:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [FW-1:0] f_out_data;
  logic f_clear;
  logic [7:0] dev_byte;

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      a0_s_q <= 2'h0;
      a1_s_q <= 2'h0;
      a2_s_q <= 2'h0;
      wg_s_q <= 2'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else if (ce_i) begin
      scl_s_q <= {scl_s_q[0], scl_i}; // RULE_12
      sda_s_q <= {sda_s_q[0], sda_i};
      a0_s_q <= {a0_s_q[0], addr_strap_bit0_i}; // RULE_10
      a1_s_q <= {a1_s_q[0], addr_strap_bit1_i};
      a2_s_q <= {a2_s_q[0], addr_strap_bit2_i};
      wg_s_q <= {wg_s_q[0], write_guard_i};
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end

  assign scl_rise = scl_s_q[1] && !scl_d1_q; // RULE_14
  assign scl_fall = !scl_s_q[1] && scl_d1_q;
  assign start_c = scl_s_q[1] && scl_d1_q && sda_d1_q && !sda_s_q[1];
  assign stop_c = scl_s_q[1] && scl_d1_q && !sda_d1_q && sda_s_q[1];
  assign dev_byte = {eep_pkg::DEV_CODE, a2_s_q[1], a1_s_q[1], a0_s_q[1], 1'b0}; // RULE_01

  // Page buffer entries: address and data
  assign f_in_valid = (st_q == eep_pkg::EEP_WDATA) && scl_fall && sda_oe_q
    && ack_data_q && f_in_ready; // RULE_08
  assign f_in_data = {ptr_q, sh_q};
  assign f_out_ready = (wst_q == eep_pkg::EEP_WR_PROG);
  assign f_clear = start_c && (wst_q == eep_pkg::EEP_WR_IDLE);

  eep_fifo #(
    .WIDTH(FW),
    .DEPTH(eep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .clear_i(f_clear),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in_data),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out_data)
  );

  // Bus protocol engine
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_q <= eep_pkg::EEP_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rd_mode_q <= 1'b0;
      ack_to_addr_q <= 1'b0;
      ptr_q <= 8'h00;
      pg_cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      ack_data_q <= 1'b0;
      rd_first_q <= 1'b0;
    end else if (ce_i) begin
      if (stop_c) begin
        st_q <= eep_pkg::EEP_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start_c) begin
        st_q <= eep_pkg::EEP_DEVADDR;
        bit_q <= 3'h0;
        pg_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
        ack_data_q <= 1'b0;
        rd_first_q <= 1'b0;
      end else begin
        case (st_q)
          eep_pkg::EEP_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          eep_pkg::EEP_DEVADDR, eep_pkg::EEP_WADDR, eep_pkg::EEP_WDATA: begin
            if (scl_fall && sda_oe_q) begin
              sda_oe_q <= 1'b0; // RULE_04
              if ((st_q == eep_pkg::EEP_WDATA) && ack_data_q) begin
                if (pg_cnt_q != 4'(eep_pkg::PAGE_BYTES)) begin
                  pg_cnt_q <= pg_cnt_q + 4'h1; // RULE_08
                end
                ptr_q <= {ptr_q[7:3], 3'(ptr_q[2:0] + 3'h1)}; // RULE_08
              end
            end else if (scl_rise && !sda_oe_q) begin
              sh_q <= {sh_q[6:0], sda_s_q[1]}; // RULE_03
              bit_q <= bit_q + 3'h1;
              if (bit_q == eep_pkg::BIT_LAST) begin
                st_q <= eep_pkg::EEP_ACK;
                ack_to_addr_q <= (st_q == eep_pkg::EEP_DEVADDR);
                ack_data_q <= (st_q == eep_pkg::EEP_WDATA);
                rd_mode_q <= (st_q == eep_pkg::EEP_DEVADDR) ? sda_s_q[1] : rd_mode_q;
              end
            end
          end
          eep_pkg::EEP_ACK: begin
            if (scl_fall) begin
              if (ack_to_addr_q) begin
                if ((sh_q[7:1] == dev_byte[7:1]) && !busy_q) begin // RULE_02 RULE_16
                  sda_oe_q <= 1'b1; // RULE_11
                  st_q <= rd_mode_q ? eep_pkg::EEP_RDATA : eep_pkg::EEP_WADDR;
                  rd_first_q <= rd_mode_q;
                  if (rd_mode_q) begin
                    sh_q <= mem_q[ptr_q];
                  end
                end else begin
                  st_q <= eep_pkg::EEP_SKIP;
                end
              end else begin
                sda_oe_q <= 1'b1;
                st_q <= eep_pkg::EEP_WDATA;
                // Word address byte loads the pointer
                if (!ack_data_q) begin
                  ptr_q <= sh_q; // RULE_07
                end
              end
            end
          end
          eep_pkg::EEP_RDATA: begin
            if (scl_fall) begin
              sda_oe_q <= !sh_q[7]; // RULE_04 RULE_11
              rd_first_q <= 1'b0;
            end else if (scl_rise && !rd_first_q) begin
              sh_q <= {sh_q[6:0], 1'b1};
              bit_q <= bit_q + 3'h1;
              if (bit_q == eep_pkg::BIT_LAST) begin
                st_q <= eep_pkg::EEP_RACK;
                ptr_q <= ptr_q + 8'h01; // RULE_13
              end
            end
          end
          eep_pkg::EEP_RACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
              if (sda_s_q[1]) begin
                st_q <= eep_pkg::EEP_SKIP;
              end else begin
                st_q <= eep_pkg::EEP_RDATA; // RULE_13
                sh_q <= mem_q[ptr_q];
                bit_q <= 3'h0;
              end
            end
          end
          eep_pkg::EEP_SKIP: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            st_q <= eep_pkg::EEP_IDLE;
          end
        endcase
      end
    end
  end

  // Write cycle: drain page buffer after stop, then wait out the cycle
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wst_q <= eep_pkg::EEP_WR_IDLE;
      wcnt_q <= 32'h0;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      case (wst_q)
        eep_pkg::EEP_WR_IDLE: begin
          if (stop_c && f_out_valid) begin
            wst_q <= eep_pkg::EEP_WR_PROG; // RULE_09
            busy_q <= 1'b1;
            wcnt_q <= 32'h0;
          end
        end
        eep_pkg::EEP_WR_PROG: begin
          wcnt_q <= wcnt_q + 32'h1;
          if (!f_out_valid) begin
            wst_q <= eep_pkg::EEP_WR_WAIT;
          end
        end
        eep_pkg::EEP_WR_WAIT: begin
          wcnt_q <= wcnt_q + 32'h1;
          if (wcnt_q >= WR_CYCLES) begin // RULE_09
            wst_q <= eep_pkg::EEP_WR_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          wst_q <= eep_pkg::EEP_WR_IDLE;
        end
      endcase
    end
  end

  // Array write port
  always_ff @(posedge clock_i) begin
    if (ce_i && f_out_ready && f_out_valid) begin
      if (!(wg_s_q[1] && f_out_data[FW-1])) begin // RULE_05 RULE_06
        mem_q[f_out_data[FW-1:eep_pkg::DW]] <= f_out_data[eep_pkg::DW-1:0];
      end
    end
  end

  // Open-drain data level, from a flop
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sda_lo_q <= 1'b0;
    end else if (ce_i) begin
      sda_lo_q <= 1'b0;
    end
  end

  assign sda_o = sda_lo_q; // RULE_11
  assign sda_oe_o = sda_oe_q;
  assign busy_o = busy_q;
endmodule

// file: testbench/eep_slave_monitor.sv
/*
  Pin checker for eep_slave.
  Bound to every eep_slave instance.
*/
`timescale 1ns/100ps
module eep_slave_monitor #(
  parameter int unsigned WR_CYCLES = 200
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic busy_o
);
  int unsigned bcnt_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Busy length counter
  always_ff @(posedge clock_i) begin
    if (!nrst_i || !busy_o) begin
      bcnt_q <= 0;
    end else if (ce_i) begin
      bcnt_q <= bcnt_q + 1;
    end
  end
  property p_od; sda_o == 1'b0; endproperty
  a_od: assert property (p_od)
    else $error("sda_o not low");
  property p_rst; !$past(nrst_i) |-> !sda_oe_o && !busy_o; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
  property p_edge; $changed(sda_oe_o) |-> !$past(scl_i, 3); endproperty
  a_edge: assert property (p_edge)
    else $error("sda drive changed outside scl low");
  property p_busy_ack; busy_o |-> !$rose(sda_oe_o); endproperty
  a_busy_ack: assert property (p_busy_ack)
    else $error("ack while busy");
  property p_busy_min; $rose(busy_o) |-> busy_o [*8]; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  property p_busy_max; bcnt_q <= WR_CYCLES + 16; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy too long");
  property p_stop; $rose(busy_o) |-> scl_i && sda_i; endproperty
  a_stop: assert property (p_stop)
    else $error("busy without stop");
  property p_ce; !ce_i |=> $stable(sda_oe_o) && $stable(busy_o); endproperty
  a_ce: assert property (p_ce)
    else $error("outputs moved while frozen");
endmodule
bind eep_slave eep_slave_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon (
  .clock_i(clock_i),
  .nrst_i(nrst_i),
  .ce_i(ce_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .busy_o(busy_o)
);

// file: testbench/eep_bus_master.sv
/*
  Two-wire bus master model, 8 clocks per bit.
  Assumes the bench resolves SDA with a pull-up.
*/
`timescale 1ns/100ps
module eep_bus_master (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Frame opens only on our request
  task automatic bstart();
    pull_o <= 1'b0;
    w(2);
    scl_o <= 1'b1;
    w(4);
    pull_o <= 1'b1;
    w(4);
    scl_o <= 1'b0;
    w(2);
  endtask
  task automatic bstop();
    pull_o <= 1'b1;
    w(2);
    scl_o <= 1'b1;
    w(4);
    pull_o <= 1'b0;
    w(4);
  endtask
  task automatic bit_x(input logic d, output logic s);
    pull_o <= !d;
    w(2);
    scl_o <= 1'b1;
    w(2);
    s = sda_i;
    w(2);
    scl_o <= 1'b0;
    w(2);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      b[i] = s;
    end
    bit_x(last, s);
  endtask
endmodule

// file: testbench/eep_slave_bench.sv
/*
  Bench for eep_slave: page writes, reads, guard and strap match.
  Assumes the master model drives the pins.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module eep_slave_bench;
  logic clock_i;
  logic nrst_i;
  logic ce_i;
  logic guard;
  logic busy;
  logic oe;
  logic sdo;
  logic scl;
  logic pull;
  logic ack;
  logic [2:0] strap;
  logic [7:0] rd;
  logic [7:0] pg[$];
  int err_total;
  int checked;
  wire sda = !pull && (!oe || sdo);
  eep_bus_master i_mst (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  eep_slave #(.WR_CYCLES(200)) i_dut (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sdo),
    .sda_oe_o(oe),
    .addr_strap_bit0_i(strap[0]),
    .addr_strap_bit1_i(strap[1]),
    .addr_strap_bit2_i(strap[2]),
    .write_guard_i(guard),
    .busy_o(busy)
  );
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic final_report();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] da(input logic r);
    return {eep_pkg::DEV_CODE, strap, r};
  endfunction
  task automatic dev(input logic [7:0] b, input logic e);
    i_mst.wbyte(b, ack);
    `CHK("ack", e, ack)
  endtask
  task automatic wait_idle();
    int i;
    repeat (8) @(posedge clock_i);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clock_i);
    if (i == 400) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic ee_write(input logic [7:0] a, input logic [7:0] d[$]);
    i_mst.bstart();
    dev(da(1'b0), 1'b1);
    dev(a, 1'b1);
    foreach (d[i]) dev(d[i], 1'b1);
    i_mst.bstop();
  endtask
  task automatic ee_read(input logic [7:0] a, input logic [7:0] e[$]);
    i_mst.bstart();
    dev(da(1'b0), 1'b1);
    dev(a, 1'b1);
    i_mst.bstart();
    dev(da(1'b1), 1'b1);
    foreach (e[i]) begin
      i_mst.rbyte(i == e.size() - 1, rd);
      `CHK("data", e[i], rd)
    end
    i_mst.bstop();
  endtask
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    guard = 1'b0;
    strap = 3'h5;
    for (int i = 0; i < 8; i++) pg.push_back(8'h10 + 8'(i));
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    ee_write(8'h10, pg);
    repeat (8) @(posedge clock_i);
    `CHK("busy", 1'b1, busy)
    ce_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    `CHK("frozen", 1'b1, busy)
    ce_i <= 1'b1;
    i_mst.bstart();
    dev(da(1'b0), 1'b0);
    i_mst.bstop();
    wait_idle();
    ee_read(8'h10, pg);
    ee_write(8'h80, '{8'h5A, 8'hA5, 8'h3C});
    wait_idle();
    guard <= 1'b1;
    ee_write(8'h7F, '{8'h77});
    wait_idle();
    ee_write(8'h80, '{8'h33});
    wait_idle();
    ee_read(8'h7F, '{8'h77, 8'h5A, 8'hA5, 8'h3C});
    strap <= 3'h2;
    @(posedge clock_i);
    i_mst.bstart();
    dev({eep_pkg::DEV_CODE, 3'h5, 1'b0}, 1'b0);
    i_mst.bstart();
    dev(da(1'b0), 1'b1);
    i_mst.bstop();
    final_report();
  end
endmodule
